// ==== verilog/line_scan_pkg.sv ====
// Package of shared constants for the linear array readout sequencer and its controller.
//==================================================================
// Overview of operation
// - Integration equals start-to-freeze interval minus 18 clocks.
// - Sampled scan-start pulse begins a new readout cycle.
// - Controller spaces scan starts by at least n+1 clocks.
// - Controller may idle, total interval under 100 ms; host caps only its H_WAIT extension, H_IDLE waits on start_scan unbounded.
// - Scan start freezes all pixels, presents pixel one.
// - Each clock advances output to the next pixel.
// - Integrators held reset during start and 17 clocks.
// - Nineteenth clock releases integrators, integration begins.
// - First 18 pixels output while integrators reset.
// - Pixel resumes sampling the clock after its output; here pixels 1-17 wait for the integrator release.
// - Clock n+1 ends readout, output goes high impedance.
// - Controller waits 20 us charge transfer before restart.
// - Integration at least period times (n-18) plus 20 us.
// - Array clock never faster than 8 MHz.
// - After power-up, flush one frame before trusting data.
// - Controller parks the array clock low when idle.
// - Previous frame reads out while next one integrates.
// - Each pixel value stays valid for whole clock period.
// - Scan-start and freeze share one pulse.
// - 124 inner, 2 next-to-end, 2 end pixels; pixel 1 first.
// - Scan start returns low together with the next (falling) clock edge, before the next rising edge.
package line_scan_pkg;
   localparam int PIXEL_COUNT      = 128;
   localparam int INNER_PIXELS     = 124;
   localparam int NEAR_END_PIXELS  = 2;
   localparam int END_PIXELS       = 2;
   localparam int SETUP_CLOCKS     = 18;
   localparam int PIXEL_WIDTH      = 8;
   localparam int CLK_PERIOD_NS    = 8;
   localparam int ARRAY_CLK_MAX_KHZ = 8000;
   localparam int SYS_CLK_KHZ      = 125000;
   // Divide by at least the rounded-up ratio so the array clock never exceeds its limit.
   localparam int ARRAY_HALF_DIV   = (SYS_CLK_KHZ + 2 * ARRAY_CLK_MAX_KHZ - 1)
                                     / (2 * ARRAY_CLK_MAX_KHZ);
   localparam int CHARGE_XFER_US   = 20;
   localparam int CHARGE_XFER_CYC  = (CHARGE_XFER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_FRAME_MS     = 100;
   localparam int MAX_FRAME_CYC    = MAX_FRAME_MS * 1000000 / CLK_PERIOD_NS;
endpackage

// ==== verilog/line_scan_if.sv ====
// Interface joining the array sequencer and its controller.
`timescale 1ns/1ps
interface line_scan_if;
   logic                                  scan_start;
   logic                                  array_clk;
   logic [line_scan_pkg::PIXEL_WIDTH-1:0] analog_pixel_out;
   logic                                  pixel_out_oe;
   modport device (input scan_start, input array_clk, output analog_pixel_out, output pixel_out_oe);
   modport host   (output scan_start, output array_clk, input analog_pixel_out, input pixel_out_oe);
endinterface

// ==== verilog/line_scan_device.sv ====
// Array end: pixel freeze, integrator reset timing and sequential readout.
`timescale 1ns/1ps
module line_scan_device #(
   parameter int N_PIX = line_scan_pkg::PIXEL_COUNT,
   parameter int PW    = line_scan_pkg::PIXEL_WIDTH
) (
   input  wire logic          clk,
   input  wire logic          reset,
   line_scan_if.device        link,
   input  wire logic [PW-1:0] pixel_level [N_PIX],
   output logic               integrator_reset_switch,
   output logic [N_PIX-1:0]   sample_select_switch,
   output logic [7:0]         read_index
);
   typedef enum logic [1:0] {IDLE, READ} dev_state_e;
   dev_state_e       state_r;
   logic             clk_d_r;
   logic [PW-1:0]    held_r [N_PIX];
   logic [7:0]       count_r;
   logic [PW-1:0]    out_r;
   logic             oe_r;
   logic             rise;
   //==================================================================
   // Array clock edge detection
   always_ff @(posedge clk) clk_d_r <= reset ? 1'b0 : link.array_clk;
   assign rise = link.array_clk & ~clk_d_r;
   //==================================================================
   // Sequencer
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r <= IDLE;
         count_r <= 8'h00;
      end
      else if (rise && link.scan_start)
      begin
         state_r <= READ;
         count_r <= 8'h01;
      end
      else if (rise && state_r == READ)
      begin
         count_r <= count_r + 8'h01;
         if (count_r == 8'(N_PIX))
            state_r <= IDLE;
      end
   end
   //==================================================================
   // Hold capacitors: all pixels frozen at once, last frame read while next integrates.
   generate
      for (genvar i = 0; i < N_PIX; i++)
      begin : g_hold
         always_ff @(posedge clk)
         begin
            if (reset)
               held_r[i] <= '0;
            else if (rise && link.scan_start)
               held_r[i] <= pixel_level[i];
         end
         // Pixel i samples unless frozen; it resumes the clock after its output, pixels 1-17 not before the integrator release.
         always_ff @(posedge clk)
         begin
            if (reset)
               sample_select_switch[i] <= 1'b1;
            else if (rise && link.scan_start)
               sample_select_switch[i] <= 1'b0;
            else if (rise && state_r == READ && count_r >= 8'(line_scan_pkg::SETUP_CLOCKS)
                     && count_r >= 8'(i + 1))
               sample_select_switch[i] <= 1'b1;
         end
      end
   endgenerate
   //==================================================================
   // Integrator reset: start edge plus 17 clocks, released on the 19th.
   always_ff @(posedge clk)
   begin
      if (reset)
         integrator_reset_switch <= 1'b0;
      else if (rise && link.scan_start)
         integrator_reset_switch <= 1'b1;
      else if (rise && count_r == 8'(line_scan_pkg::SETUP_CLOCKS))
         integrator_reset_switch <= 1'b0;
   end
   //==================================================================
   // Output drive, steady for whole array clock period. Pixel 1 is index 0.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         out_r <= '0;
         oe_r  <= 1'b0;
      end
      else if (rise && link.scan_start)
      begin
         out_r <= pixel_level[0];
         oe_r  <= 1'b1;
      end
      else if (rise && state_r == READ)
      begin
         if (count_r < 8'(N_PIX))
            out_r <= held_r[count_r[$clog2(N_PIX)-1:0]];
         else
         begin
            out_r <= '0;
            oe_r  <= 1'b0;
         end
      end
   end
   assign link.analog_pixel_out = out_r;
   assign link.pixel_out_oe     = oe_r;
   always_ff @(posedge clk) read_index <= reset ? 8'h00 : count_r;
endmodule // line_scan_device

// ==== verilog/line_scan_host.sv ====
// Controller end: makes the array clock and scan pulses and captures pixels.
`timescale 1ns/1ps
module line_scan_host #(
   parameter int N_PIX       = line_scan_pkg::PIXEL_COUNT,
   parameter int PW          = line_scan_pkg::PIXEL_WIDTH,
   parameter int HALF_DIV    = line_scan_pkg::ARRAY_HALF_DIV,
   parameter int XFER_CYC    = line_scan_pkg::CHARGE_XFER_CYC,
   parameter int MAX_FRM_CYC = line_scan_pkg::MAX_FRAME_CYC
) (
   input  wire logic          clk,
   input  wire logic          reset,
   line_scan_if.host          link,
   input  wire logic          start_scan,
   input  wire logic [31:0]   extra_wait,
   output logic [PW-1:0]      pixel_data,
   output logic               pixel_valid,
   output logic [7:0]         pixel_index,
   output logic               frame_trusted,
   output logic               busy
);
   typedef enum logic [2:0] {H_IDLE, H_START, H_CLOCK, H_WAIT} host_state_e;
   host_state_e   state_r;
   logic [7:0]    div_r;
   logic          aclk_r;
   logic          si_r;
   logic [7:0]    clocks_r;
   logic [31:0]   wait_r;
   logic [31:0]   wait_extra;
   logic [31:0]   frame_r;
   logic          flushed_r;
   logic          tick;
   assign tick = (div_r == 8'(HALF_DIV - 1));
   // Charge transfer time is always served; the extension stops early once the whole
   // frame nears its limit, leaving a few cycles for the restart's own latency.
   assign wait_extra = wait_r - 32'(XFER_CYC);
   always_ff @(posedge clk)
   begin
      if (reset || state_r == H_IDLE || state_r == H_WAIT)
         div_r <= 8'h00;
      else
         div_r <= tick ? 8'h00 : div_r + 8'h01;
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r   <= H_IDLE;
         aclk_r    <= 1'b0;
         si_r      <= 1'b0;
         clocks_r  <= 8'h00;
         wait_r    <= '0;
         flushed_r <= 1'b0;
         frame_trusted <= 1'b0;
      end
      else
      begin
         case (state_r)
            H_IDLE:
               if (start_scan)
               begin
                  si_r    <= 1'b1;
                  state_r <= H_START;
               end
            H_START:
               if (tick)
               begin
                  aclk_r   <= ~aclk_r;
                  if (aclk_r)
                     si_r <= 1'b0;
                  else
                     clocks_r <= 8'h01;
                  if (aclk_r)
                     state_r <= H_CLOCK;
               end
            H_CLOCK:
               if (tick)
               begin
                  aclk_r <= ~aclk_r;
                  if (!aclk_r)
                     clocks_r <= clocks_r + 8'h01;
                  else if (clocks_r == 8'(N_PIX + 1))
                  begin
                     state_r <= H_WAIT;
                     wait_r  <= '0;
                  end
               end
            H_WAIT:
            begin
               wait_r <= wait_r + 32'h1;
               if (wait_r >= 32'(XFER_CYC)
                   && (wait_extra >= extra_wait || frame_r >= 32'(MAX_FRM_CYC - 4)))
               begin
                  state_r       <= H_IDLE;
                  frame_trusted <= flushed_r;
                  flushed_r     <= 1'b1;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end
   // Capture each pixel late in its clock period, inside its valid window.
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pixel_data  <= '0;
         pixel_valid <= 1'b0;
         pixel_index <= 8'h00;
      end
      else
      begin
         pixel_valid <= 1'b0;
         if (tick && !aclk_r && link.pixel_out_oe && clocks_r >= 8'h01
             && clocks_r <= 8'(N_PIX) && state_r != H_IDLE)
         begin
            pixel_data  <= link.analog_pixel_out;
            pixel_valid <= 1'b1;
            pixel_index <= clocks_r - 8'h01;
         end
      end
   end
   always_ff @(posedge clk) busy <= reset ? 1'b0 : (state_r != H_IDLE || start_scan);
   always_ff @(posedge clk) frame_r <= reset ? '0 : (state_r == H_IDLE ? '0 : frame_r + 32'h1);
   assign link.array_clk  = aclk_r;
   assign link.scan_start = si_r;
endmodule // line_scan_host

// ==== tb/line_scan_chk.sv ====
// Concurrent checks on the link between the array sequencer and its controller.
`timescale 1ns/1ps
module line_scan_chk #(
   parameter int PW       = line_scan_pkg::PIXEL_WIDTH,
   parameter int XFER_CYC = line_scan_pkg::CHARGE_XFER_CYC
) (
   input wire logic          clk,
   input wire logic          reset,
   input wire logic          scan_start,
   input wire logic          array_clk,
   input wire logic [PW-1:0] analog_pixel_out,
   input wire logic          pixel_out_oe
);
   // ==========
   // Frame tracking; the start rise counts as rise zero.
   logic        clk_q_r;
   logic        in_frame_r;
   logic [7:0]  rise_cnt_r;
   logic [15:0] idle_r;
   wire         rise = array_clk && !clk_q_r;
   wire         go   = rise && scan_start;
   wire         last = rise && in_frame_r && rise_cnt_r == 8'h7F;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   always_ff @(posedge clk) clk_q_r <= !reset && array_clk;
   always_ff @(posedge clk) in_frame_r <= !reset && (go || (in_frame_r && !last));
   always_ff @(posedge clk) rise_cnt_r <= (reset || go) ? 8'h00 : rise_cnt_r + 8'(rise);
   // Saturated after reset so the first start is never judged early.
   always_ff @(posedge clk)
      idle_r <= reset ? 16'hFFFF : in_frame_r ? 16'h0000 : idle_r + 16'(idle_r != 16'hFFFF);
   a_start_idle_only: assert property (go |-> !in_frame_r)
      else $error("scan start inside a frame");
   a_xfer_gap: assert property (go |-> idle_r >= 16'(XFER_CYC))
      else $error("scan start before transfer time");
   a_rise_needs_start: assert property (rise && !in_frame_r |-> scan_start)
      else $error("array clock rise while idle");
   a_clk_slow: assert property (rise |=> !rise [*8] ##1 !rise [*7])
      else $error("array clock too fast");
   a_oe_in_frame: assert property ((go || in_frame_r) && !last |=> pixel_out_oe)
      else $error("output not driven in frame");
   a_hiz_end: assert property (last |=> !pixel_out_oe && analog_pixel_out == '0)
      else $error("output driven after last pixel");
   a_hiz_idle: assert property (!in_frame_r && !go |=> !pixel_out_oe)
      else $error("output driven while idle");
   a_value_held: assert property (!rise |=> $stable(analog_pixel_out))
      else $error("pixel value changed mid period");
   c_start: cover property (go);
   c_end: cover property (last);
   c_quick_restart: cover property (go && idle_r < 16'h0100);
endmodule // line_scan_chk

// ==== tb/line_scan_tb.sv ====
// Bench joining controller and sequencer and checking the delivered pixel stream.
`timescale 1ns/1ps
module linear_array_readout_sequencer_tb;
   localparam int N  = line_scan_pkg::PIXEL_COUNT;
   localparam int SU = line_scan_pkg::SETUP_CLOCKS;
   localparam logic [N-1:0] ALL_ON = '1;
   logic         clk = 1'h0;
   logic         reset = 1'h1;
   logic         start_scan = 1'h0;
   logic [31:0]  extra_wait = 32'h0;
   logic [7:0]   pixel_level [N];
   logic [7:0]   base;
   logic [7:0]   pixel_data;
   logic [7:0]   pixel_index;
   logic [7:0]   read_index;
   logic [N-1:0] sample_select_switch;
   logic         integrator_reset_switch;
   logic         pixel_valid, frame_trusted, busy;
   int           n_fail = 0;
   int           samples_checked = 0;
   int           n_pix = 0, cycles = 0;
   always #4 clk = ~clk;
   line_scan_if link ();
   line_scan_device i_line_scan_device (.clk(clk), .reset(reset), .link(link),
      .pixel_level(pixel_level), .integrator_reset_switch(integrator_reset_switch),
      .sample_select_switch(sample_select_switch), .read_index(read_index));
   line_scan_host #(.XFER_CYC(10), .MAX_FRM_CYC(5000)) i_line_scan_host (.clk(clk),
      .reset(reset), .link(link), .start_scan(start_scan), .extra_wait(extra_wait),
      .pixel_data(pixel_data), .pixel_valid(pixel_valid), .pixel_index(pixel_index),
      .frame_trusted(frame_trusted), .busy(busy));
   line_scan_chk #(.XFER_CYC(10)) i_line_scan_chk (.clk(clk), .reset(reset),
      .scan_start(link.scan_start), .array_clk(link.array_clk),
      .analog_pixel_out(link.analog_pixel_out), .pixel_out_oe(link.pixel_out_oe));
   // ==========
   // Shared tasks and the pixel monitor.
   task automatic test_done;
      if (n_fail == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      samples_checked++;
      if (ok !== 1'h1)
      begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // Every wait after reset passes through here, so the ceiling also cuts any hang short.
   task automatic tick;
      @(posedge clk);
      #1;
      cycles++;
      if (cycles > 20000)
      begin
         check(1'h0, "timeout");
         test_done();
      end
   endtask
   always @(posedge clk)
      if (pixel_valid === 1'h1)
      begin
         check(pixel_index === 8'(n_pix), "pixel order");
         check(pixel_data === base + 8'(n_pix * 5), "frozen value");
         check(integrator_reset_switch === (n_pix < SU), "reset");
         check(sample_select_switch === (n_pix < SU ? '0 : ALL_ON >> (N-n_pix)), "sel");
         check(read_index === 8'(n_pix + 1), "read index");
         n_pix++;
      end
   // Live levels are inverted mid-readout; the held values must not follow them.
   task automatic frame(input logic [7:0] b, input logic [31:0] extra, input logic trust);
      base = b;
      extra_wait = extra;
      for (int i = 0; i < N; i++)
         pixel_level[i] = b + 8'(i * 5);
      while (busy !== 1'h0) tick();
      n_pix = 0;
      start_scan = 1'h1;
      tick();
      start_scan = 1'h0;
      while (n_pix < 60) tick();
      for (int i = 0; i < N; i++)
         pixel_level[i] = ~pixel_level[i];
      start_scan = 1'h1;
      tick();
      start_scan = 1'h0;
      while (n_pix < N || busy !== 1'h0) tick();
      check(frame_trusted === trust, "trust flag");
      check(&sample_select_switch && link.pixel_out_oe === 1'h0, "idle state");
   endtask
   initial
   begin
      pixel_level = '{default: 8'h00};
      repeat (8) @(posedge clk);
      #1 reset = 1'h0;
      frame(8'h10, 32'h0, 1'h0);
      frame(8'hA3, 32'h0, 1'h1);
      frame(8'h5C, 32'h40, 1'h1);
      repeat (300) tick();
      test_done();
   end
endmodule // linear_array_readout_sequencer_tb
